// file: design/xcvr_defines.svh
// constants for the transceiver reset, power-down and status block
// assumes a 40 MHz system clock and a 32-bit plain register port
`ifndef XCVR_DEFINES_SVH
`define XCVR_DEFINES_SVH

// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STAT 8'h08
`define ADDR_IRQ_MASK 8'h0C

// control register: write-one start strobes, read as zero
`define CTRL_START_ANALOG 0
`define CTRL_START_CHANNEL 1
`define CTRL_START_PLL 2

// status register fields
`define ST_PLL_LOCK 0
`define ST_FREQ_LOCK 1
`define ST_BUSY 2
`define ST_POWERDOWN 3
`define ST_PLL_RESET 4
`define ST_CDR_MODE_LO 5
`define ST_REF_LOCK_STATE 7

// interrupt status and mask fields
`define IRQ_LOCK_GAIN 0
`define IRQ_LOCK_LOSS 1
`define IRQ_BUSY_DONE 2
`define IRQ_LTD_GAIN 3
`define IRQ_WIDTH 4
`define IRQ_RESET 4'h0

// clock rates and the reconfiguration clock divider
`define SYS_CLK_MHZ 40
`define RCFG_CLK_MHZ 10
`define RCFG_DIV (`SYS_CLK_MHZ / `RCFG_CLK_MHZ)

// durations in ns, least times rounded up to whole cycles
`define OC_TIME_NS 20000
`define ANALOG_TIME_NS 5000
`define CHANNEL_TIME_NS 10000
`define PLLCFG_TIME_NS 8000
`define PLLRST_TIME_NS 500
`define PLL_LOCK_TIME_NS 10000
`define CDR_LTD_TIME_NS 4000
`define OC_TICKS ((`OC_TIME_NS * `RCFG_CLK_MHZ + 999) / 1000)
`define ANALOG_TICKS ((`ANALOG_TIME_NS * `RCFG_CLK_MHZ + 999) / 1000)
`define CHANNEL_TICKS ((`CHANNEL_TIME_NS * `RCFG_CLK_MHZ + 999) / 1000)
`define PLLCFG_TICKS ((`PLLCFG_TIME_NS * `RCFG_CLK_MHZ + 999) / 1000)
`define PLLRST_TICKS ((`PLLRST_TIME_NS * `RCFG_CLK_MHZ + 999) / 1000)
`define PLL_LOCK_CYCLES ((`PLL_LOCK_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define CDR_LTD_CYCLES ((`CDR_LTD_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// file: design/xcvr_pkg.sv
// types shared by the transceiver reset and status block
// assumes the constants header is compiled alongside
`default_nettype none
package xcvr_pkg;
  // reconfiguration controller states, gray along init-oc-idle-cfg-pllrst
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_OC = 3'b001,
    ST_IDLE = 3'b011,
    ST_RECFG = 3'b010,
    ST_PLLRST = 3'b110
  } rcfg_state_t;
  // clock recovery lock mode, {force data, force reference}
  typedef enum logic [1:0] {
    CDR_AUTO = 2'b00,
    CDR_MAN_REF = 2'b01,
    CDR_MAN_DATA = 2'b10,
    CDR_MAN_DATA2 = 2'b11
  } cdr_mode_t;
  // kind of dynamic reconfiguration in progress
  typedef enum logic [1:0] {
    CFG_ANALOG = 2'b00,
    CFG_CHANNEL = 2'b01,
    CFG_PLL = 2'b10
  } cfg_kind_t;
endpackage
`default_nettype wire

// file: design/sync3.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous levels; one clock domain
`default_nettype none
module sync3 #(
  parameter int W = 6
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // one chain per bit; output follows once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        s1_q[i] <= async_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: design/xcvr_reset_pd_status.sv
// reset, power-down and status logic of a transceiver block
// assumes fabric drives the control pins asynchronously and software
// uses the plain register port on the 40 MHz system clock
`include "xcvr_defines.svh"
`default_nettype none
// Summary of operation
// - after PLL reconfiguration the controller pulses PLL reset by itself
// - power-off input powers down PCS and PMA of every channel
// - power-off acts regardless of every other reset input
// - one power-off input serves the whole block, not each channel
// - PLL lock flag high when PLL locked to reference clock
// - data-lock flag high in lock-to-data, low in lock-to-reference
// - busy stays low for the first reconfiguration clock cycle
// - busy rises from the second reconfiguration clock cycle
// - busy after power-up means offset cancellation is running
// - busy falls only once offset cancellation has finished
// - busy also stands for each whole dynamic reconfiguration
// - mode 00 automatic, 01 manual reference, 1x manual data lock
// - power-off also resets TX FIFO, serializer and 8B/10B encoder
module xcvr_reset_pd_status
  import xcvr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic PLL_RESET_IN,
  input wire logic POWERDOWN_IN,
  input wire logic FORCE_DATA_LOCK_IN,
  input wire logic FORCE_REF_LOCK_IN,
  input wire logic REF_CLK_OK_IN,
  input wire logic SIG_DETECT_IN,
  output logic PLL_RESET_OUT,
  output logic PLL_LOCK_OUT,
  output logic FREQ_LOCK_OUT,
  output logic BUSY_OUT,
  output logic PCS_PD_OUT,
  output logic PMA_PD_OUT,
  output logic TX_FIFO_RST_OUT,
  output logic SERIALIZER_RST_OUT,
  output logic ENCODER_RST_OUT,
  output logic IRQ_OUT
);
  localparam logic [1:0] DIV_LAST = 2'(`RCFG_DIV - 1);
  localparam logic [11:0] OC_TICKS = 12'(`OC_TICKS);
  localparam logic [11:0] ANALOG_TICKS = 12'(`ANALOG_TICKS);
  localparam logic [11:0] CHANNEL_TICKS = 12'(`CHANNEL_TICKS);
  localparam logic [11:0] PLLCFG_TICKS = 12'(`PLLCFG_TICKS);
  localparam logic [11:0] PLLRST_TICKS = 12'(`PLLRST_TICKS);
  localparam logic [11:0] LOCK_CYCLES = 12'(`PLL_LOCK_CYCLES);
  localparam logic [11:0] LTD_CYCLES = 12'(`CDR_LTD_CYCLES);

  logic [5:0] sync_w;
  logic user_rst_s;
  logic pd_s;
  logic ref_ok_s;
  logic sigdet_s;
  cdr_mode_t mode_s;

  logic [1:0] div_q;
  rcfg_state_t state_q;
  rcfg_state_t state_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  cfg_kind_t kind_q;
  cfg_kind_t kind_d;
  logic busy_q;
  logic pll_rst_q;
  logic [11:0] lock_cnt_q;
  logic lock_q;
  logic [11:0] ltd_cnt_q;
  logic ltd_q;
  logic pd_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic irq_q;
  logic [31:0] rdata_q;

  // pin inputs pass the three-stage filter
  sync3 #(.W(6)) u_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .async_in({SIG_DETECT_IN, REF_CLK_OK_IN, FORCE_REF_LOCK_IN,
               FORCE_DATA_LOCK_IN, POWERDOWN_IN, PLL_RESET_IN}),
    .sync_out(sync_w)
  );

  assign user_rst_s = sync_w[0];
  assign pd_s = sync_w[1];
  assign mode_s = cdr_mode_t'({sync_w[2], sync_w[3]});
  assign ref_ok_s = sync_w[4];
  assign sigdet_s = sync_w[5];

  // register port decode
  wire wr_ctrl = WR_IN && (ADDR_IN == `ADDR_CTRL);
  wire wr_istat = WR_IN && (ADDR_IN == `ADDR_IRQ_STAT);
  wire wr_mask = WR_IN && (ADDR_IN == `ADDR_IRQ_MASK);
  wire go_analog = wr_ctrl && WDATA_IN[`CTRL_START_ANALOG];
  wire go_channel = wr_ctrl && WDATA_IN[`CTRL_START_CHANNEL];
  wire go_pll = wr_ctrl && WDATA_IN[`CTRL_START_PLL];
  wire start_any = go_analog || go_channel || go_pll;
  // analog wins over channel, channel over PLL when several are set
  wire cfg_kind_t start_kind = go_analog ? CFG_ANALOG :
                               go_channel ? CFG_CHANNEL : CFG_PLL;
  wire [11:0] start_len = go_analog ? ANALOG_TICKS :
                          go_channel ? CHANNEL_TICKS : PLLCFG_TICKS;

  // reconfiguration clock enable, one pulse every RCFG_DIV cycles
  wire rcfg_tick = (div_q == DIV_LAST);
  wire cnt_last = (cnt_q <= 12'h001);
  wire [11:0] cnt_dec = cnt_q - 12'h001;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_q <= 2'h0;
    end else begin
      div_q <= rcfg_tick ? 2'h0 : div_q + 2'h1;
    end
  end

  // reconfiguration controller next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    case (state_q)
      ST_INIT: begin
        if (rcfg_tick) begin
          state_d = ST_OC;
          cnt_d = OC_TICKS;
        end
      end
      ST_OC: begin
        if (rcfg_tick) begin
          cnt_d = cnt_last ? 12'h000 : cnt_dec;
          if (cnt_last) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (start_any) begin
          state_d = ST_RECFG;
          cnt_d = start_len;
          kind_d = start_kind;
        end
      end
      ST_RECFG: begin
        if (rcfg_tick) begin
          cnt_d = cnt_last ? 12'h000 : cnt_dec;
          if (cnt_last && kind_q == CFG_PLL) begin
            state_d = ST_PLLRST;
            cnt_d = PLLRST_TICKS;
          end else if (cnt_last) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_PLLRST: begin
        if (rcfg_tick) begin
          cnt_d = cnt_last ? 12'h000 : cnt_dec;
          if (cnt_last) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_INIT;
        cnt_d = 12'h000;
      end
    endcase
  end

  // busy stands in every state other than start-up and idle
  wire busy_d = (state_d != ST_INIT) && (state_d != ST_IDLE);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_INIT;
      cnt_q <= 12'h000;
      kind_q <= CFG_ANALOG;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      busy_q <= busy_d;
    end
  end

  // PLL reset from the user pin or from the controller after a PLL
  // reconfiguration; the power-off level plays no part here
  wire pll_rst_d = user_rst_s || (state_d == ST_PLLRST);

  // PLL lock: needs reset released and the reference running
  wire lock_hold = pll_rst_q || !ref_ok_s;
  wire lock_d = !lock_hold && (lock_q || (lock_cnt_q == LOCK_CYCLES));

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pll_rst_q <= 1'b0;
      lock_cnt_q <= 12'h000;
      lock_q <= 1'b0;
    end else begin
      pll_rst_q <= pll_rst_d;
      lock_cnt_q <= (lock_hold || lock_q) ? 12'h000 : lock_cnt_q + 12'h001;
      lock_q <= lock_d;
    end
  end

  // clock recovery: forced modes act at once, automatic mode moves to
  // lock-to-data once the PLL is locked and signal stays present
  wire auto_ok = lock_q && sigdet_s && (mode_s == CDR_AUTO) && !pd_s;
  wire auto_ltd = auto_ok && (ltd_cnt_q == LTD_CYCLES);
  wire ltd_d = pd_s ? 1'b0 :
               mode_s[1] ? 1'b1 :
               (mode_s == CDR_MAN_REF) ? 1'b0 : auto_ltd;
  wire lock_to_reference_state = !ltd_q;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ltd_cnt_q <= 12'h000;
      ltd_q <= 1'b0;
    end else begin
      ltd_cnt_q <= (!auto_ok) ? 12'h000 :
                   auto_ltd ? ltd_cnt_q : ltd_cnt_q + 12'h001;
      ltd_q <= ltd_d;
    end
  end

  // single block-wide power-off flop feeds PCS, PMA and TX resets
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= pd_s;
    end
  end

  // interrupt events; a set in the clearing cycle wins
  wire [3:0] irq_ev = {ltd_d && !ltd_q, busy_q && !busy_d,
                       lock_q && !lock_d, !lock_q && lock_d};
  wire [3:0] irq_clr = wr_istat ? WDATA_IN[3:0] : `IRQ_RESET;
  wire [3:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;
  wire [3:0] irq_mask_d = wr_mask ? WDATA_IN[3:0] : irq_mask_q;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_stat_q <= `IRQ_RESET;
      irq_mask_q <= `IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= |(irq_stat_d & irq_mask_d);
    end
  end

  // read data selection; unmapped and control reads give zero
  wire [31:0] status_w = {24'h000000, lock_to_reference_state, mode_s,
                          pll_rst_q, pd_q, busy_q, ltd_q, lock_q};
  wire [31:0] rd_mux = (ADDR_IN == `ADDR_STATUS) ? status_w :
                       (ADDR_IN == `ADDR_IRQ_STAT) ? {28'h0, irq_stat_q} :
                       (ADDR_IN == `ADDR_IRQ_MASK) ? {28'h0, irq_mask_q} :
                       32'h00000000;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= RD_IN ? rd_mux : 32'h00000000;
    end
  end

  // outputs straight from flops
  assign RDATA_OUT = rdata_q;
  assign PLL_RESET_OUT = pll_rst_q;
  assign PLL_LOCK_OUT = lock_q;
  assign FREQ_LOCK_OUT = ltd_q;
  assign BUSY_OUT = busy_q;
  assign PCS_PD_OUT = pd_q;
  assign PMA_PD_OUT = pd_q;
  assign TX_FIFO_RST_OUT = pd_q;
  assign SERIALIZER_RST_OUT = pd_q;
  assign ENCODER_RST_OUT = pd_q;
  assign IRQ_OUT = irq_q;

  // power-off reaches PCS and PMA one cycle after the filtered level
  chk_pd_pcs_pma: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    pd_s |=> (PCS_PD_OUT && PMA_PD_OUT))
    else $error("power-off did not power down pcs and pma");

  chk_pd_tx_resets: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(pd_s) |=> (TX_FIFO_RST_OUT && SERIALIZER_RST_OUT &&
                     ENCODER_RST_OUT))
    else $error("power-off did not reset tx fifo, serializer, encoder");

  chk_pd_pll_indep: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (pd_s && !user_rst_s) |=> (PLL_RESET_OUT == (state_q == ST_PLLRST)))
    else $error("power-off disturbed the pll reset");

  chk_pll_auto_rst: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (state_q == ST_RECFG && kind_q == CFG_PLL && rcfg_tick && cnt_last)
    |=> PLL_RESET_OUT [*4])
    else $error("pll reset not driven after pll reconfiguration");

  chk_lock_reset: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (PLL_RESET_OUT || !ref_ok_s) |=> !PLL_LOCK_OUT)
    else $error("pll lock high while pll held in reset");

  chk_cdr_force: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (mode_s[1] && !pd_s) |=> FREQ_LOCK_OUT)
    else $error("forced lock-to-data not reflected");

  chk_cdr_ref: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (mode_s == CDR_MAN_REF) |=> !FREQ_LOCK_OUT)
    else $error("data-lock flag high in lock-to-reference mode");

  chk_busy_first: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (state_q == ST_INIT) |-> !BUSY_OUT)
    else $error("busy high during first reconfiguration cycle");

  chk_busy_second: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (state_q == ST_INIT && rcfg_tick) |=> (BUSY_OUT && state_q == ST_OC))
    else $error("busy not raised at second reconfiguration cycle");

  chk_busy_oc_done: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    $fell(BUSY_OUT) |-> ($past(rcfg_tick) && $past(cnt_q) <= 12'h001))
    else $error("busy fell before its countdown finished");

  chk_busy_recfg: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (state_q == ST_IDLE && start_any) |=> BUSY_OUT [*8])
    else $error("busy not held during reconfiguration");
endmodule
`default_nettype wire

// file: bench/fabric_model.sv
// fabric-side model driving the block's control pins
// assumes the bench calls set_pins just after a rising clock edge
`default_nettype none
module fabric_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pll_lock_in,
  input wire logic busy_in,
  output logic pll_reset_out,
  output logic [4:0] pins_out,
  output logic dig_rst_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] seq_q = 5'h00;
  logic user_rst_q = 1'b0;
  logic dig_q = 1'b1;
  logic [4:0] pins_q = 5'b00011;
  // start-up: PLL held in reset, lanes held until locked and idle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_q <= 5'h00;
      dig_q <= 1'b1;
    end else begin
      if (!seq_q[4]) seq_q <= seq_q + 5'h01;
      if (seq_q[4] && pll_lock_in && !busy_in) dig_q <= 1'b0;
    end
  end
  // pins: power-off, {force data, force ref}, ref clock ok, signal
  assign pins_out = pins_q;
  assign pll_reset_out = user_rst_q | ~seq_q[4];
  assign dig_rst_out = dig_q;
  // new pin levels and user PLL reset request
  task automatic set_pins(input logic [4:0] p, input logic r);
    pins_q <= p;
    user_rst_q <= r;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_transceiver_reset_powerdown_status.sv
// self-checking bench for the transceiver reset and status block
// assumes the design files and the fabric model are compiled first
`include "xcvr_defines.svh"
`default_nettype none
module tb_transceiver_reset_powerdown_status;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] lfsr_q = 32'h57C3;
  logic f;
  int miscompares = 0;
  int tests_run = 0;
  int cnt = 0;
  note_t notes_q[$];
  note_t n;
  wire [31:0] rdata;
  wire [4:0] pins;
  wire [4:0] pdv;
  wire pll_rst_pin, pll_rst, pll_lock, freq_lock, busy, irq, dig_rst;
  wire [2:0] obs = {pll_rst, pll_lock, busy};

  xcvr_reset_pd_status uut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PLL_RESET_IN(pll_rst_pin),
    .POWERDOWN_IN(pins[4]), .FORCE_DATA_LOCK_IN(pins[3]),
    .FORCE_REF_LOCK_IN(pins[2]), .REF_CLK_OK_IN(pins[1]),
    .SIG_DETECT_IN(pins[0]), .PLL_RESET_OUT(pll_rst),
    .PLL_LOCK_OUT(pll_lock), .FREQ_LOCK_OUT(freq_lock), .BUSY_OUT(busy),
    .PCS_PD_OUT(pdv[4]), .PMA_PD_OUT(pdv[3]), .TX_FIFO_RST_OUT(pdv[2]),
    .SERIALIZER_RST_OUT(pdv[1]), .ENCODER_RST_OUT(pdv[0]), .IRQ_OUT(irq));

  fabric_model fab (
    .clk_in(clk), .rst_n_in(rst_n), .pll_lock_in(pll_lock),
    .busy_in(busy), .pll_reset_out(pll_rst_pin), .pins_out(pins),
    .dig_rst_out(dig_rst));

  // clock and cycle count
  always #12.5 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 1;

  // compare the oldest read note with the data of the cycle after
  always @(posedge clk) begin
    if (rd_seen) begin
      n = notes_q.pop_front();
      check(rdata & n.m, n.e);
    end
    rd_seen <= rd;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask

  // bus cycles: strobe for one edge, then one idle edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    notes_q.push_back('{e & m, m});
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // bounded wait for one output level, 0 busy, 1 lock, 2 PLL reset
  task automatic wait_for(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && obs[s] !== v; i++) @(posedge clk);
    if (obs[s] !== v) begin
      miscompares++;
      $display("timeout at %0t", $time);
      wrap_up();
    end
  endtask

  // busy duration from t0 must be lo-3 to lo cycles: the first tick of
  // a request may come one to four cycles after the start edge
  task automatic dur(input int t0, input int lo);
    int d;
    wait_for(0, 1'b0, 1000);
    d = cnt - t0;
    check((d >= lo - 3 && d <= lo) ? lo : d, lo);
  endtask

  // one reconfiguration, optionally poked again while busy
  task automatic recfg(input logic [31:0] c, input int lo, input bit pk);
    int t0;
    wr_reg(`ADDR_CTRL, c);
    t0 = cnt;
    check(busy, 1'b1);
    if (pk) wr_reg(`ADDR_CTRL, 32'h1);
    rd_reg(`ADDR_STATUS, 32'h4, 32'h4);
    if (c == 32'h4) begin
      wait_for(2, 1'b1, 400);
      check(busy, 1'b1);
    end
    dur(t0, lo);
    check(pll_rst, 1'b0);
  endtask

  initial begin
    step(10);
    rst_n <= 1'b1;
    repeat (3) begin
      step(1);
      check(busy, 1'b0);
    end
    step(5);
    check(busy, 1'b1);
    dur(cnt - 3, `OC_TICKS * 4);
    check(pll_lock, 1'b1);
    rd_reg(`ADDR_STATUS, 32'hFF, 32'h03);
    rd_reg(`ADDR_IRQ_STAT, 32'hF, 32'hD);
    wr_reg(`ADDR_IRQ_STAT, 32'hF);
    rd_reg(`ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    check(dig_rst, 1'b0);
    $display("done: start-up");
    fab.set_pins(5'b00001, 1'b0);
    wait_for(1, 1'b0, 10);
    fab.set_pins(5'b00011, 1'b0);
    wait_for(1, 1'b1, 600);
    $display("done: lock");
    for (int m = 0; m < 4; m++) begin
      fab.set_pins({1'b0, m[1:0], 2'b11}, 1'b0);
      step(200);
      f = (m != 1);
      check(freq_lock, f);
      rd_reg(`ADDR_STATUS, 32'hFF, {24'h0, ~f, m[1:0], 3'b0, f, 1'b1});
    end
    $display("done: lock modes");
    for (int p = 0; p < 2; p++) begin
      fab.set_pins(5'b10011, p[0]);
      step(8);
      check(pdv, 5'h1F);
      check(freq_lock, 1'b0);
      check(pll_rst, p[0]);
      fab.set_pins(5'b10011, ~p[0]);
      step(8);
      check(pdv, 5'h1F);
      rd_reg(`ADDR_STATUS, 32'h18, {27'h0, ~p[0], 1'b1, 3'b0});
    end
    fab.set_pins(5'b00011, 1'b0);
    step(8);
    check(pdv, 5'h00);
    check(pll_rst, 1'b0);
    wait_for(1, 1'b1, 600);
    $display("done: power-off");
    wr_reg(`ADDR_IRQ_STAT, 32'hF);
    wr_reg(`ADDR_IRQ_MASK, 32'h4);
    recfg(32'h7, `ANALOG_TICKS * 4, 1'b1);
    step(2);
    check(irq, 1'b1);
    wr_reg(`ADDR_IRQ_STAT, 32'h4);
    step(1);
    check(irq, 1'b0);
    wr_reg(`ADDR_IRQ_MASK, 32'h0);
    recfg(32'h2, `CHANNEL_TICKS * 4, 1'b0);
    step(2);
    check(irq, 1'b0);
    rd_reg(`ADDR_IRQ_STAT, 32'h4, 32'h4);
    wr_reg(`ADDR_IRQ_MASK, 32'h4);
    step(2);
    check(irq, 1'b1);
    wr_reg(`ADDR_IRQ_STAT, 32'hF);
    recfg(32'h4, (`PLLCFG_TICKS + `PLLRST_TICKS) * 4, 1'b0);
    $display("done: reconfiguration");
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      wr_reg(`ADDR_IRQ_MASK, lfsr_q);
      rd_reg(`ADDR_IRQ_MASK, 32'hFFFFFFFF, {28'h0, lfsr_q[3:0]});
    end
    wr_reg(8'h10, lfsr_q);
    rd_reg(8'h10, 32'hFFFFFFFF, 32'h0);
    rd_reg(`ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    $display("done: registers");
    step(2);
    wrap_up();
  end
endmodule
`default_nettype wire
